/* File: rtl/ccv_pkg.sv */
package ccv_pkg;
   localparam logic [3:0] CCV_ADR_CTRL = 4'h0;
   localparam logic [3:0] CCV_ADR_CAPSRC = 4'h4;
   localparam logic [3:0] CCV_ADR_VAL_LO = 4'h8;
   localparam logic [3:0] CCV_ADR_VAL_HI = 4'hC;
   localparam logic [31:0] CCV_ADR_STATUS = 32'h0000_0010;
   localparam logic [7:0] CCV_CTRL_RESET = 8'h00;
   localparam logic [2:0] CCV_CAPSRC_RESET = 3'h0;
   localparam logic [7:0] CCV_VAL_RESET = 8'h00;
   localparam int CCV_CTRL_EN_BIT = 7;
   localparam int CCV_CTRL_OUT_BIT = 5;
   localparam int CCV_CTRL_FMT_BIT = 4;
   localparam int CCV_STAT_FLAG_BIT = 0;
   localparam int CCV_STAT_TSEL_BIT = 1;
   localparam int CCV_STAT_ADCSEL_BIT = 2;
   localparam logic [1:0] CCV_PRE4_LAST = 2'h3;
   localparam logic [3:0] CCV_PRE16_LAST = 4'hF;
   localparam logic [3:0] CCV_M_OFF = 4'h0;
   localparam logic [3:0] CCV_M_TOG_CLR = 4'h1;
   localparam logic [3:0] CCV_M_TOG = 4'h2;
   localparam logic [3:0] CCV_M_CAP_ANY = 4'h3;
   localparam logic [3:0] CCV_M_CAP_FALL = 4'h4;
   localparam logic [3:0] CCV_M_CAP_RISE = 4'h5;
   localparam logic [3:0] CCV_M_CAP_R4 = 4'h6;
   localparam logic [3:0] CCV_M_CAP_R16 = 4'h7;
   localparam logic [3:0] CCV_M_SET = 4'h8;
   localparam logic [3:0] CCV_M_CLR = 4'h9;
   localparam logic [3:0] CCV_M_PULSE = 4'hA;
   localparam logic [3:0] CCV_M_PULSE_CLR = 4'hB;

   typedef enum logic [2:0] {
      CCV_KIND_OFF = 3'b001,
      CCV_KIND_CAP = 3'b010,
      CCV_KIND_CMP = 3'b100
   } ccv_kind_e;

   // the eight selectable capture trigger levels
   typedef struct packed {
      logic logic_cell_four_output;
      logic logic_cell_three_output;
      logic logic_cell_two_output;
      logic logic_cell_one_output;
      logic pin_change_interrupt;
      logic comparator_two_output;
      logic comparator_one_output;
      logic remapped_input_pin;
   } ccv_trig_s;

   // one selectable time source: capture/compare timer and pwm base, used together
   typedef struct packed {
      logic [15:0] capcmp_timer;
      logic [9:0] pwm_base;
   } ccv_time_s;
endpackage

/* File: rtl/ccv_unit.sv */
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ccv_unit (
   input wire logic clk_sys, // 40 MHz system clock
   input wire logic reset_n, // async reset, active low
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [31:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire ccv_pkg::ccv_trig_s trig_in, // trigger source levels
   input wire ccv_pkg::ccv_time_s time_a, // first selectable time source
   input wire ccv_pkg::ccv_time_s time_b, // second selectable time source
   input wire logic timer_select, // this unit's own time source choice
   input wire logic adc_trigger_select, // unit chosen as converter trigger
   output logic unit_out, // compare/pwm output pin level
   output logic timer_clear, // pulse: clear the capture/compare timer
   output logic unit_interrupt_flag, // sticky event flag
   output logic adc_start // pulse: start a conversion
);
   import ccv_pkg::*;

   logic [7:0] ctrl_reg;
   logic [2:0] capsrc_reg;
   logic [7:0] val_lo_reg;
   logic [7:0] val_hi_reg;
   logic out_reg;
   logic flag_reg;
   logic trig_reg;
   logic [3:0] edge_cnt_reg;
   logic pulse_reg;
   logic [9:0] duty_reg;
   logic ack_reg;
   logic [31:0] rdat_reg;
   logic tclr_reg;
   logic adc_reg;
   logic [3:0] mode;
   logic en;
   ccv_kind_e kind;
   ccv_time_s tsrc;
   logic trig_now;
   logic rise;
   logic fall;
   logic cap_event;
   logic match;
   logic cmp_event;
   logic pwm_mode;
   logic [9:0] pwm_width;
   logic pwm_wrap;
   logic unit_event;
   logic bus_req;
   logic wr_stb;
   logic wr_ctrl;
   logic flag_clr;

   assign mode = ctrl_reg[3:0];
   assign en = ctrl_reg[CCV_CTRL_EN_BIT];
   assign pwm_mode = (mode[3:2] == 2'b11);
   // per-unit private time source choice; nothing shared between instances
   assign tsrc = timer_select ? time_b : time_a;

   // mode classification
   always_comb begin
      kind = CCV_KIND_OFF;
      case (mode)
         CCV_M_CAP_ANY, CCV_M_CAP_FALL, CCV_M_CAP_RISE, CCV_M_CAP_R4, CCV_M_CAP_R16: begin
            kind = CCV_KIND_CAP;
         end
         CCV_M_TOG_CLR, CCV_M_TOG, CCV_M_SET, CCV_M_CLR, CCV_M_PULSE, CCV_M_PULSE_CLR: begin
            kind = CCV_KIND_CMP;
         end
         default: begin
            kind = CCV_KIND_OFF;
         end
      endcase
   end

   // trigger source mux
   assign trig_now = trig_in[capsrc_reg];
   assign rise = trig_now & ~trig_reg;
   assign fall = ~trig_now & trig_reg;

   // capture event decode with edge prescaler
   always_comb begin
      case (mode)
         CCV_M_CAP_ANY: cap_event = rise | fall;
         CCV_M_CAP_FALL: cap_event = fall;
         CCV_M_CAP_RISE: cap_event = rise;
         CCV_M_CAP_R4: cap_event = rise && (edge_cnt_reg[1:0] == CCV_PRE4_LAST);
         CCV_M_CAP_R16: cap_event = rise && (edge_cnt_reg == CCV_PRE16_LAST);
         default: cap_event = 1'b0;
      endcase
      cap_event = cap_event & en & (kind == CCV_KIND_CAP);
   end

   // full 16-bit compare, both bytes in the same cycle
   assign match = (tsrc.capcmp_timer[7:0] == val_lo_reg)
      && (tsrc.capcmp_timer[15:8] == val_hi_reg);
   assign cmp_event = en && (kind == CCV_KIND_CMP) && match;

   // pwm width packing by alignment; format ignored outside pwm
   assign pwm_width = ctrl_reg[CCV_CTRL_FMT_BIT] ? {val_hi_reg, val_lo_reg[7:6]}
      : {val_hi_reg[1:0], val_lo_reg};
   assign pwm_wrap = en && pwm_mode && (tsrc.pwm_base == 10'h000);
   assign unit_event = cap_event | cmp_event | pwm_wrap;

   // wishbone decode; one registered ack per request, a cycle after it
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_stb = bus_req & wb_we_i & wb_sel_i[0];
   assign wr_ctrl = wr_stb && (wb_adr_i == {28'h0000000, CCV_ADR_CTRL});
   assign flag_clr = wr_stb && (wb_adr_i == CCV_ADR_STATUS) && wb_dat_i[CCV_STAT_FLAG_BIT];

   // trigger history and edge prescaler; prescaler cleared when unit is off, not capturing, or on any control write
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trig_reg <= 1'b0;
         edge_cnt_reg <= 4'h0;
      end else begin
         trig_reg <= trig_now;
         if (!en || kind != CCV_KIND_CAP || wr_ctrl) begin
            edge_cnt_reg <= 4'h0;
         end else if (rise) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
         end
      end
   end

   // control and source select registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= CCV_CTRL_RESET;
         capsrc_reg <= CCV_CAPSRC_RESET;
      end else if (wr_stb) begin
         if (wb_adr_i == {28'h0000000, CCV_ADR_CTRL}) begin
            ctrl_reg <= {wb_dat_i[7], 1'b0, 1'b0, wb_dat_i[4:0]};
         end
         if (wb_adr_i == {28'h0000000, CCV_ADR_CAPSRC}) begin
            capsrc_reg <= wb_dat_i[2:0];
         end
      end
   end

   // value pair: capture wins over a software write in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         val_lo_reg <= CCV_VAL_RESET;
         val_hi_reg <= CCV_VAL_RESET;
      end else if (cap_event) begin
         val_lo_reg <= tsrc.capcmp_timer[7:0];
         val_hi_reg <= tsrc.capcmp_timer[15:8];
      end else if (wr_stb) begin
         if (wb_adr_i == {28'h0000000, CCV_ADR_VAL_LO}) begin
            val_lo_reg <= wb_dat_i[7:0];
         end
         if (wb_adr_i == {28'h0000000, CCV_ADR_VAL_HI}) begin
            val_hi_reg <= wb_dat_i[7:0];
         end
      end
   end

   // pwm duty double buffer, latched at period wrap to avoid glitches
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         duty_reg <= 10'h000;
      end else if (pwm_wrap) begin
         duty_reg <= pwm_width;
      end
   end

   // output pin state per mode; mode 0000 resets it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= 1'b0;
         if (mode == CCV_M_OFF || !en) begin
            out_reg <= 1'b0;
         end else if (pwm_mode) begin
            out_reg <= (tsrc.pwm_base < duty_reg);
         end else if (cmp_event) begin
            case (mode)
               CCV_M_SET: out_reg <= 1'b1;
               CCV_M_CLR: out_reg <= 1'b0;
               CCV_M_TOG, CCV_M_TOG_CLR: out_reg <= ~out_reg;
               CCV_M_PULSE, CCV_M_PULSE_CLR: pulse_reg <= 1'b1;
               default: out_reg <= out_reg;
            endcase
         end
      end
   end

   // event side effects: sticky flag (set beats clear), timer clear, conversion start
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         flag_reg <= 1'b0;
         tclr_reg <= 1'b0;
         adc_reg <= 1'b0;
      end else begin
         if (unit_event) begin
            flag_reg <= 1'b1;
         end else if (flag_clr) begin
            flag_reg <= 1'b0;
         end
         tclr_reg <= cmp_event && (mode == CCV_M_PULSE_CLR || mode == CCV_M_TOG_CLR);
         adc_reg <= unit_event & adc_trigger_select;
      end
   end

   // bus answer: ack one cycle after request, read data registered
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= bus_req;
         if (bus_req) begin
            case (wb_adr_i)
               {28'h0000000, CCV_ADR_CTRL}: rdat_reg <= {24'h000000, ctrl_reg[7], 1'b0, out_reg | pulse_reg, ctrl_reg[4:0]};
               {28'h0000000, CCV_ADR_CAPSRC}: rdat_reg <= {29'h00000000, capsrc_reg};
               {28'h0000000, CCV_ADR_VAL_LO}: rdat_reg <= {24'h000000, val_lo_reg};
               {28'h0000000, CCV_ADR_VAL_HI}: rdat_reg <= {24'h000000, val_hi_reg};
               CCV_ADR_STATUS: rdat_reg <= {29'h00000000, adc_trigger_select, timer_select, flag_reg};
               default: rdat_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign unit_out = out_reg | pulse_reg;
   assign timer_clear = tclr_reg;
   assign unit_interrupt_flag = flag_reg;
   assign adc_start = adc_reg;
endmodule
`default_nettype wire

/* File: test/ccv_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ccv_unit_monitor (
   input wire logic clk_sys, // clock
   input wire logic reset_n, // reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [31:0] wb_adr_i, // address
   input wire logic [3:0] wb_sel_i, // lanes
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // ack
   input wire logic adc_trigger_select, // converter pick
   input wire logic timer_clear, // clear pulse
   input wire logic unit_interrupt_flag, // flag
   input wire logic adc_start // start pulse
);
   import ccv_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic req;
   logic w1c;
   // a request counts only while ack is low, so the ack cycle itself is no new request
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign w1c = req && wb_we_i && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == CCV_ADR_STATUS;
   chk_ack_next: assert property (req |=> wb_ack_o)
      else $error("ack missing");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_capsrc_high: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == CCV_ADR_CAPSRC |-> wb_dat_o[7:3] == 5'h00) else $error("source high bits");
   chk_flag_sticky: assert property (
      unit_interrupt_flag && !w1c |=> unit_interrupt_flag) else $error("flag dropped");
   chk_adc_sel: assert property (
      adc_start |-> $past(adc_trigger_select)) else $error("start while unselected");
   chk_adc_flag: assert property (
      adc_start |-> unit_interrupt_flag) else $error("start without flag");
   chk_clr_flag: assert property (
      timer_clear |-> unit_interrupt_flag) else $error("clear without flag");
   cov_write: cover property (req && wb_we_i);
   cov_adc: cover property (adc_start);
   cov_clear: cover property (timer_clear);
endmodule
bind ccv_unit ccv_unit_monitor u_mon (.*);
`default_nettype wire

/* File: test/ccv_far.sv */
`timescale 1ns/1ps
`default_nettype none
module ccv_far (
   input wire logic clk_sys, // clock
   input wire logic reset_n, // reset
   input wire logic run, // timer counts
   input wire logic ld, // load timer
   input wire logic [15:0] ld_val, // load value
   input wire logic [7:0] lvl, // trigger levels
   input wire logic timer_clear, // clear from unit
   output var ccv_pkg::ccv_trig_s trig_in, // trigger sources
   output var ccv_pkg::ccv_time_s time_a, // source a
   output var ccv_pkg::ccv_time_s time_b // source b
);
   import ccv_pkg::*;
   logic [15:0] cnt_reg;
   logic [9:0] pwm_reg;
   // capture/compare timer; a load from the bench wins over the unit's clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) cnt_reg <= 16'h0000;
      else if (ld) cnt_reg <= ld_val;
      else if (timer_clear) cnt_reg <= 16'h0000;
      else if (run) cnt_reg <= cnt_reg + 16'h0001;
   end
   // free pwm base, period 1024 cycles
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) pwm_reg <= 10'h000;
      else pwm_reg <= pwm_reg + 10'h001;
   end
   // source b carries the inverted timer and the same pwm base, so picking the wrong timer shows
   assign time_a = {cnt_reg, pwm_reg};
   assign time_b = {~cnt_reg, pwm_reg};
   assign trig_in = lvl;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ccv_pkg::*;
   logic clk_sys, ack, uo, tclr, flag, adst;
   logic reset_n = 0, cyc = 0, stb = 0, we = 0, tsel = 0, asel = 0, run = 0, ld = 0;
   logic [31:0] adr = 0, wd = 0, rd, rdv;
   logic [15:0] ldv = 0;
   logic [7:0] lvl = 0;
   ccv_trig_s trg;
   ccv_time_s ta, tb2;
   int num_errors = 0, n_compared = 0, cyc_n = 0;
   ccv_unit u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .trig_in(trg),
      .time_a(ta), .time_b(tb2), .timer_select(tsel), .adc_trigger_select(asel), .unit_out(uo),
      .timer_clear(tclr), .unit_interrupt_flag(flag), .adc_start(adst));
   ccv_far u_far (.clk_sys(clk_sys), .reset_n(reset_n), .run(run), .ld(ld), .ld_val(ldv), .lvl(lvl),
      .timer_clear(tclr), .trig_in(trg), .time_a(ta), .time_b(tb2));
   // 25 ns clock
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic end_of_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge clk_sys) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one classic cycle; the request holds until ack is seen at an edge
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      @(posedge clk_sys iff ack === 1'b1);
      rdv = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rchk(input logic [31:0] a, e);
      bus(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask
   task automatic t_regs;
      rchk(CCV_ADR_CTRL, 32'h0);
      rchk(CCV_ADR_CAPSRC, 32'h0);
      rchk(CCV_ADR_VAL_HI, 32'h0);
      bus(1'b1, CCV_ADR_CAPSRC, 32'hFF);
      rchk(CCV_ADR_CAPSRC, 32'h07);
      bus(1'b1, 32'h1C, 32'h5A);
      rchk(32'h1C, 32'h0);
   endtask
   // each source in turn: others move first and must not capture
   task automatic t_cap;
      logic [15:0] v;
      for (int s = 0; s < 8; s++) begin
         v = 16'hA5C3 + 16'(s) * 16'h0111;
         ld <= 1'b1;
         ldv <= v;
         bus(1'b1, CCV_ADR_CAPSRC, 32'(s));
         ld <= 1'b0;
         bus(1'b1, CCV_ADR_CTRL, 32'h85);
         bus(1'b1, CCV_ADR_STATUS, 32'h01);
         lvl <= ~(8'h01 << s);
         repeat (3) @(posedge clk_sys);
         chk(flag, 32'h0);
         lvl <= 8'hFF;
         repeat (3) @(posedge clk_sys);
         chk(flag, 32'h1);
         rchk(CCV_ADR_VAL_LO, v[7:0]);
         rchk(CCV_ADR_VAL_HI, v[15:8]);
         lvl <= 8'h00;
      end
   endtask
   task automatic t_pre;
      logic [3:0] m [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
      int n [5] = '{1, 1, 1, 4, 16};
      bus(1'b1, CCV_ADR_CAPSRC, 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, CCV_ADR_CTRL, {24'h0, 4'h8, m[i]});
         bus(1'b1, CCV_ADR_STATUS, 32'h01);
         for (int k = 1; k <= n[i]; k++) begin
            lvl <= 8'h01;
            repeat (3) @(posedge clk_sys);
            chk(flag, 32'(m[i] != 4'h4 && k == n[i]));
            lvl <= 8'h00;
            repeat (3) @(posedge clk_sys);
            chk(flag, 32'(k == n[i]));
         end
      end
   endtask
   // timer starts at 0x0100 and runs 80 cycles; the converter pick follows source a
   task automatic t_cmp(input logic [3:0] m, input logic s, input logic [15:0] t, input logic hit, o);
      logic sc, sa, su;
      {sc, sa, su} = 3'b000;
      tsel <= s;
      asel <= ~s;
      ld <= 1'b1;
      ldv <= 16'h0100;
      bus(1'b1, CCV_ADR_VAL_LO, {24'h0, t[7:0]});
      ld <= 1'b0;
      bus(1'b1, CCV_ADR_VAL_HI, {24'h0, t[15:8]});
      bus(1'b1, CCV_ADR_CTRL, {24'h0, 4'h8, m});
      bus(1'b1, CCV_ADR_STATUS, 32'h01);
      run <= 1'b1;
      repeat (80) begin
         @(posedge clk_sys);
         {sc, sa, su} = {sc | tclr === 1'b1, sa | adst === 1'b1, su | uo === 1'b1};
      end
      run <= 1'b0;
      chk(flag, 32'(hit));
      chk(uo, 32'(o));
      chk(sc, 32'(hit && (m == 4'hB || m == 4'h1)));
      chk(sa, 32'(hit && !s));
      if (m[3:1] == 3'b101) chk(su, 32'h1);
   endtask
   task automatic t_pwm(input logic [7:0] c, lo, hi, input int w);
      int h;
      h = 0;
      bus(1'b1, CCV_ADR_VAL_LO, {24'h0, lo});
      bus(1'b1, CCV_ADR_VAL_HI, {24'h0, hi});
      bus(1'b1, CCV_ADR_CTRL, {24'h0, c});
      repeat (1100) @(posedge clk_sys);
      repeat (1024) begin
         @(posedge clk_sys);
         h += int'(uo === 1'b1);
      end
      chk(h, w);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_regs();
      t_cap();
      t_pre();
      t_cmp(4'h8, 1'b0, 16'h0123, 1'b1, 1'b1);
      t_cmp(4'h9, 1'b1, 16'hFECF, 1'b1, 1'b0);
      t_cmp(4'hA, 1'b0, 16'h0123, 1'b1, 1'b0);
      t_cmp(4'hB, 1'b0, 16'h0123, 1'b1, 1'b0);
      t_cmp(4'h2, 1'b0, 16'h0123, 1'b1, 1'b1);
      t_cmp(4'h1, 1'b0, 16'h0123, 1'b1, 1'b0);
      t_cmp(4'h8, 1'b0, 16'h0223, 1'b0, 1'b0);
      t_pwm(8'h8C, 8'h40, 8'hFD, 320);
      t_pwm(8'h9C, 8'hFF, 8'h50, 323);
      end_of_test();
   end
endmodule
`default_nettype wire
